// ### rtl/sarseq_pkg.sv
// ============================================================
// shared constants and types of the conversion sequencer
package sarseq_pkg;

    // register offsets on the special-function bus
    localparam logic [7:0] OFS_MUX_SELECT  = 8'hA9;
    localparam logic [7:0] OFS_D_RES_LOW   = 8'hAA;
    localparam logic [7:0] OFS_D_RES_HIGH  = 8'hAB;
    localparam logic [7:0] OFS_CONFIG_MAIN = 8'hB9;
    localparam logic [7:0] OFS_A_RES_LOW   = 8'hBA;
    localparam logic [7:0] OFS_A_RES_HIGH  = 8'hBB;
    localparam logic [7:0] OFS_B_RES_LOW   = 8'hBC;
    localparam logic [7:0] OFS_B_RES_HIGH  = 8'hBD;
    localparam logic [7:0] OFS_C_RES_LOW   = 8'hBE;
    localparam logic [7:0] OFS_C_RES_HIGH  = 8'hBF;
    localparam logic [7:0] OFS_CTRL_STATUS = 8'hCE;

    // reset values
    localparam logic [7:0] RST_MUX_SELECT  = 8'h00;
    localparam logic [7:0] RST_CONFIG_MAIN = 8'h00;
    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;

    // conv_config_main fields
    localparam int CFG_AZ_REF_BIT   = 7;
    localparam int CFG_POWER_BIT    = 6;
    localparam int CFG_IRQ_EN_BIT   = 5;
    localparam int CFG_JUSTIFY_BIT  = 4;
    localparam int CFG_AVG_LSB      = 2;
    localparam int CFG_PRE_LSB      = 0;

    // conv_control_status fields
    localparam int CS_EN_A_BIT      = 7;
    localparam int CS_FAULT_BIT     = 3;
    localparam int CS_CHOP_BIT      = 3;
    localparam int CS_AZ_OFF_BIT    = 2;
    localparam int CS_DONE_BIT      = 1;
    localparam int CS_GO_BIT        = 0;

    // timing: index of the last of the 16 converter clocks per channel conversion
    localparam logic [3:0] CONV_TICKS_LAST = 4'hF;

    // prescaler terminal counts for divide by 32, 16, 8, 4
    localparam logic [4:0] PRE_LIMIT_DIV32 = 5'h1F;
    localparam logic [4:0] PRE_LIMIT_DIV16 = 5'h0F;
    localparam logic [4:0] PRE_LIMIT_DIV8  = 5'h07;
    localparam logic [4:0] PRE_LIMIT_DIV4  = 5'h03;

    typedef enum logic {
        SARSEQ_IDLE,
        SARSEQ_CONV
    } sarseq_phase_e;

    // full state of the sequencer
    typedef struct packed {
        sarseq_phase_e   phase;
        logic [7:0]      cfg_main;
        logic [7:0]      mux_sel;
        logic [3:0]      chan_en;      // index 0 = channel A
        logic            chop_off;
        logic            az_off_bit;
        logic            done_flag;
        logic            err_flag;
        logic            go;
        logic [1:0]      ch_idx;
        logic [2:0]      samp_cnt;
        logic [3:0]      tick_cnt;
        logic [4:0]      pre_cnt;
        logic            adc_clk;
        logic            conv_start;
        logic [14:0]     acc;
        logic [47:0]     results;      // four 12-bit results, A lowest
        logic [7:0]      rdata;
    } sarseq_state_s;

    // special-function bus request
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sarseq_sfr_s;

endpackage : sarseq_pkg

// ### rtl/sarseq_top.sv
`timescale 1ns/10ps
// Functional notes
// RULE1: software powers the converter, then waits 2 us before any start
// RULE2: power bit clear means power-down; no conversion runs
// RULE3: each channel conversion lasts 16 converter clocks, chop on or off
// RULE4: software keeps converter clock at or below 4 MHz
// RULE5: two-bit divider: 00,01,10,11 give system clock /32,/16,/8,/4
// RULE6: start or trigger converts enabled channels in order A, B, C, D
// RULE7: per-channel enable bits include channels; disabled ones are skipped
// RULE8: writing 1 to go bit starts a sequence; it clears when done
// RULE9: busy reads 1 during a sequence, 0 when idle
// RULE10: done flag sets on completion and stays until software writes 0
// RULE11: interrupt raised on completion only while interrupt enable is 1
// RULE12: start during a sequence aborts it and restarts from first channel
// RULE13: start during sequence sets error flag; it clears with done flag
// RULE14: justify bit 1 left-justifies, 0 right-justifies with zero fill
// RULE15: averaging field selects 1, 2, 4 or 8 samples per channel
// RULE16: mux codes 00 route pin inputs; 11 routes bus, common-mode, bandgap
// RULE17: channel D mux: pin, temperature, supply, ptat for 00 to 11
// RULE18: chop-off bit 1 disables comparator offset chopping
// RULE19: auto-zero control written 0 disables amplifier offset zeroing
// RULE20: auto-zero reference 1 uses fixed 1 V, 0 uses converter input
// RULE21: each channel has read-only high and low result bytes
// RULE22: control register bits 3 and 0 read error and busy, write chop and go
// RULE23: hardware trigger is a one-cycle same-clock pulse, treated as start
module sarseq_top (
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        pwm_hw_trigger_i,
    input  wire logic [11:0] conv_data_i,
    output logic             converter_power_on_o,
    output logic             adc_clk_o,
    output logic             conv_start_o,
    output logic             busy_o,
    output logic [1:0]       mux_chan_o,
    output logic [1:0]       mux_sel_o,
    output logic             comparator_chop_off_o,
    output logic             amp_autozero_active_o,
    output logic             autozero_ref_sel_o,
    output logic             irq_o
);

    // ============================================================
    // helpers

    // lowest enabled channel at or above 'from'; bit 2 set when none
    function automatic logic [2:0] pick_chan(input logic [3:0] en, input logic [2:0] from);
        logic [2:0] res;
        res = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (en[i] && (3'(i) >= from)) begin
                res = {1'b0, 2'(i)};
            end
        end
        return res;
    endfunction : pick_chan

    // formats a raw 12-bit result into a high or low byte
    function automatic logic [7:0] fmt_byte(input logic [11:0] raw, input logic left,
                                            input logic high);
        logic [7:0] b;
        b = 8'h00;
        if (left) begin
            b = high ? raw[11:4] : {raw[3:0], 4'h0};
        end else begin
            b = high ? {4'h0, raw[11:8]} : raw[7:0];
        end
        return b;
    endfunction : fmt_byte

    // ============================================================
    // state

    sarseq_pkg::sarseq_state_s st_r;
    sarseq_pkg::sarseq_state_s st_nxt;
    sarseq_pkg::sarseq_sfr_s   req;

    logic        power_on;
    logic        left_just;
    logic [1:0]  avg_sel;
    logic [1:0]  pre_sel;
    logic [4:0]  pre_limit;
    logic        conv_tick;
    logic        start_req;
    logic        wr_main;
    logic        wr_ctrl;
    logic [2:0]  first_ch;
    logic [2:0]  next_ch;
    logic [2:0]  samp_last;
    logic [14:0] acc_sum;
    logic [11:0] avg_result;
    logic [11:0] res_sel;
    logic [7:0]  rd_val;

    assign req = '{addr: sfr_addr_i, wr: sfr_wr_i, rd: sfr_rd_i, wdata: sfr_wdata_i};

    // decoded configuration
    assign power_on  = st_r.cfg_main[sarseq_pkg::CFG_POWER_BIT];
    assign left_just = st_r.cfg_main[sarseq_pkg::CFG_JUSTIFY_BIT];
    assign avg_sel   = st_r.cfg_main[sarseq_pkg::CFG_AVG_LSB +: 2];
    assign pre_sel   = st_r.cfg_main[sarseq_pkg::CFG_PRE_LSB +: 2];
    assign wr_main   = req.wr && (req.addr == sarseq_pkg::OFS_CONFIG_MAIN);
    assign wr_ctrl   = req.wr && (req.addr == sarseq_pkg::OFS_CTRL_STATUS);

    // divider select
    always_comb begin
        case (pre_sel)                                              // [RULE5]
            2'b00:   pre_limit = sarseq_pkg::PRE_LIMIT_DIV32;
            2'b01:   pre_limit = sarseq_pkg::PRE_LIMIT_DIV16;
            2'b10:   pre_limit = sarseq_pkg::PRE_LIMIT_DIV8;
            default: pre_limit = sarseq_pkg::PRE_LIMIT_DIV4;
        endcase
    end

    assign conv_tick = (st_r.pre_cnt == pre_limit);

    // software go and hardware trigger start the same way; ignored while powered down
    assign start_req = power_on &&                                  // [RULE2]
                       ((wr_ctrl && req.wdata[sarseq_pkg::CS_GO_BIT])   // [RULE8]
                        || pwm_hw_trigger_i);                           // [RULE23]

    // channel picking and averaging arithmetic
    // a start sees enables written with it
    assign first_ch   = pick_chan(wr_ctrl ? {req.wdata[4], req.wdata[5], req.wdata[6],
                                             req.wdata[7]} : st_r.chan_en, 3'h0); // [RULE6]
    assign next_ch    = pick_chan(st_r.chan_en, {1'b0, st_r.ch_idx} + 3'h1); // [RULE7]
    assign samp_last  = 3'((4'h1 << avg_sel) - 4'h1);               // [RULE15]
    assign acc_sum    = st_r.acc + {3'h0, conv_data_i};
    assign avg_result = 12'(acc_sum >> avg_sel);                    // [RULE15]

    // ============================================================
    // next-state logic
    always_comb begin
        st_nxt            = st_r;
        st_nxt.conv_start = 1'b0;

        // configuration writes
        if (wr_main) begin
            st_nxt.cfg_main = req.wdata;
        end
        if (req.wr && (req.addr == sarseq_pkg::OFS_MUX_SELECT)) begin
            st_nxt.mux_sel = req.wdata;
        end
        if (wr_ctrl) begin
            for (int i = 0; i < 4; i++) begin
                st_nxt.chan_en[i] = req.wdata[sarseq_pkg::CS_EN_A_BIT - i];   // [RULE7]
            end
            st_nxt.chop_off   = req.wdata[sarseq_pkg::CS_CHOP_BIT];         // [RULE22]
            st_nxt.az_off_bit = req.wdata[sarseq_pkg::CS_AZ_OFF_BIT];
            // writing 0 clears done and error; writing 1 leaves them alone
            if (!req.wdata[sarseq_pkg::CS_DONE_BIT]) begin
                st_nxt.done_flag = 1'b0;                                    // [RULE10]
                st_nxt.err_flag  = 1'b0;                                    // [RULE13]
            end
        end

        // converter clock divider runs only while a sequence is active
        if (st_r.phase == sarseq_pkg::SARSEQ_CONV) begin
            st_nxt.pre_cnt = conv_tick ? 5'h00 : st_r.pre_cnt + 5'h01;
            st_nxt.adc_clk = (st_r.pre_cnt < (pre_limit >> 1)) ? 1'b0 : 1'b1;
        end else begin
            st_nxt.pre_cnt = 5'h00;
            st_nxt.adc_clk = 1'b0;
        end

        case (st_r.phase)
            sarseq_pkg::SARSEQ_IDLE: begin
            end
            sarseq_pkg::SARSEQ_CONV: begin
                if (conv_tick) begin
                    st_nxt.tick_cnt = st_r.tick_cnt + 4'h1;
                    if (st_r.tick_cnt == sarseq_pkg::CONV_TICKS_LAST) begin  // [RULE3]
                        st_nxt.tick_cnt   = 4'h0;
                        st_nxt.conv_start = 1'b1;
                        if (st_r.samp_cnt == samp_last) begin
                            // channel finished: store the average, move on
                            st_nxt.results[12*st_r.ch_idx +: 12] = avg_result;   // [RULE21]
                            st_nxt.acc      = 15'h0000;
                            st_nxt.samp_cnt = 3'h0;
                            if (next_ch[2]) begin
                                st_nxt.phase      = sarseq_pkg::SARSEQ_IDLE;
                                st_nxt.conv_start = 1'b0;
                                st_nxt.go         = 1'b0;                    // [RULE8]
                                st_nxt.done_flag  = 1'b1;                    // [RULE10]
                            end else begin
                                st_nxt.ch_idx = next_ch[1:0];                // [RULE6]
                            end
                        end else begin
                            st_nxt.acc      = acc_sum;
                            st_nxt.samp_cnt = st_r.samp_cnt + 3'h1;
                        end
                    end
                end
            end
            default: begin
                st_nxt.phase = sarseq_pkg::SARSEQ_IDLE;
            end
        endcase

        // a start wins over the sequence step and restarts from the first enabled channel; a power-down below still overrides it
        if (start_req) begin
            if (st_r.phase == sarseq_pkg::SARSEQ_CONV) begin
                st_nxt.err_flag = 1'b1;                                      // [RULE13]
            end
            st_nxt.tick_cnt = 4'h0;                                          // [RULE12]
            st_nxt.samp_cnt = 3'h0;
            st_nxt.acc      = 15'h0000;
            st_nxt.pre_cnt  = 5'h00;
            st_nxt.adc_clk  = 1'b0;
            if (first_ch[2]) begin
                // nothing enabled: the sequence is empty and completes at once
                st_nxt.phase     = sarseq_pkg::SARSEQ_IDLE;
                st_nxt.go        = 1'b0;
                st_nxt.done_flag = 1'b1;
            end else begin
                st_nxt.phase      = sarseq_pkg::SARSEQ_CONV;
                st_nxt.ch_idx     = first_ch[1:0];
                st_nxt.go         = 1'b1;
                st_nxt.conv_start = 1'b1;
            end
        end

        // power-down aborts a sequence without completing it
        if (!st_nxt.cfg_main[sarseq_pkg::CFG_POWER_BIT]) begin              // [RULE2]
            st_nxt.phase      = sarseq_pkg::SARSEQ_IDLE;
            st_nxt.go         = 1'b0;
            st_nxt.conv_start = 1'b0;
            st_nxt.pre_cnt    = 5'h00;
            st_nxt.adc_clk    = 1'b0;
            st_nxt.tick_cnt   = 4'h0;
            st_nxt.samp_cnt   = 3'h0;
            st_nxt.acc        = 15'h0000;
        end

        st_nxt.rdata = req.rd ? rd_val : st_r.rdata;
    end

    // ============================================================
    // register read mux; results formatted at read time
    always_comb begin
        res_sel = 12'h000;
        rd_val  = 8'h00;
        case (req.addr)
            sarseq_pkg::OFS_A_RES_LOW,
            sarseq_pkg::OFS_A_RES_HIGH: res_sel = st_r.results[11:0];
            sarseq_pkg::OFS_B_RES_LOW,
            sarseq_pkg::OFS_B_RES_HIGH: res_sel = st_r.results[23:12];
            sarseq_pkg::OFS_C_RES_LOW,
            sarseq_pkg::OFS_C_RES_HIGH: res_sel = st_r.results[35:24];
            sarseq_pkg::OFS_D_RES_LOW,
            sarseq_pkg::OFS_D_RES_HIGH: res_sel = st_r.results[47:36];
            default:                    res_sel = 12'h000;
        endcase
        case (req.addr)
            sarseq_pkg::OFS_CONFIG_MAIN: rd_val = st_r.cfg_main;
            sarseq_pkg::OFS_MUX_SELECT:  rd_val = st_r.mux_sel;
            sarseq_pkg::OFS_CTRL_STATUS: begin
                rd_val = {st_r.chan_en[0], st_r.chan_en[1], st_r.chan_en[2],
                          st_r.chan_en[3], st_r.err_flag, 1'b0,
                          st_r.done_flag, st_r.phase == sarseq_pkg::SARSEQ_CONV}; // [RULE22]
            end
            sarseq_pkg::OFS_A_RES_LOW,
            sarseq_pkg::OFS_B_RES_LOW,
            sarseq_pkg::OFS_C_RES_LOW,
            sarseq_pkg::OFS_D_RES_LOW:  rd_val = fmt_byte(res_sel, left_just, 1'b0); // [RULE14]
            sarseq_pkg::OFS_A_RES_HIGH,
            sarseq_pkg::OFS_B_RES_HIGH,
            sarseq_pkg::OFS_C_RES_HIGH,
            sarseq_pkg::OFS_D_RES_HIGH: rd_val = fmt_byte(res_sel, left_just, 1'b1); // [RULE14]
            default:                    rd_val = 8'h00;
        endcase
    end

    // ============================================================
    // state register
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_r          <= '0;
            st_r.cfg_main <= sarseq_pkg::RST_CONFIG_MAIN;
            st_r.mux_sel  <= sarseq_pkg::RST_MUX_SELECT;
            st_r.phase    <= sarseq_pkg::SARSEQ_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // outputs to the analog core
    assign sfr_rdata_o           = st_r.rdata;
    assign converter_power_on_o  = power_on;                                // [RULE2]
    assign adc_clk_o             = st_r.adc_clk;                            // [RULE5]
    assign conv_start_o          = st_r.conv_start;
    assign busy_o                = (st_r.phase == sarseq_pkg::SARSEQ_CONV); // [RULE9]
    assign mux_chan_o            = st_r.ch_idx;
    // per-channel two-bit select, channel A in the top field; the core decodes codes
    assign mux_sel_o             = st_r.mux_sel[6 - 2*st_r.ch_idx +: 2];    // [RULE16] [RULE17]
    assign comparator_chop_off_o = st_r.chop_off;                           // [RULE18]
    assign amp_autozero_active_o = st_r.az_off_bit;                         // [RULE19]
    assign autozero_ref_sel_o    = st_r.cfg_main[sarseq_pkg::CFG_AZ_REF_BIT]; // [RULE20]
    // level interrupt, gated by the enable; cleared with the done flag
    assign irq_o = st_r.done_flag & st_r.cfg_main[sarseq_pkg::CFG_IRQ_EN_BIT]; // [RULE11]

endmodule : sarseq_top

// ### sim/sarseq_monitor.sv
`timescale 1ns/10ps
// ============================================================
// port-level checks of the conversion sequencer
module sarseq_monitor (
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       pwm_hw_trigger_i,
    input wire logic       converter_power_on_o,
    input wire logic       conv_start_o,
    input wire logic       busy_o,
    input wire logic [1:0] mux_chan_o,
    input wire logic       comparator_chop_off_o,
    input wire logic       amp_autozero_active_o,
    input wire logic       autozero_ref_sel_o,
    input wire logic       irq_o
);
    logic       req_r;
    logic [9:0] gap_r;
    wire logic  wr_cs = sfr_wr_i && sfr_addr_i == sarseq_pkg::OFS_CTRL_STATUS;
    wire logic  wr_cf = sfr_wr_i && sfr_addr_i == sarseq_pkg::OFS_CONFIG_MAIN;

    // start requests, and cycles since the last conversion start
    always_ff @(posedge core_clk_i) begin
        req_r <= (wr_cs && sfr_wdata_i[0]) || pwm_hw_trigger_i;
        gap_r <= conv_start_o ? 10'h001 : gap_r + 10'h001;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    launch_go_a: assert property (
        wr_cs && sfr_wdata_i[0] && sfr_wdata_i[7] && converter_power_on_o
        |=> busy_o && conv_start_o && mux_chan_o == 2'h0) else $error("start not taken");
    conv_gap_a: assert property (
        conv_start_o && !req_r |-> gap_r inside {10'h040, 10'h080, 10'h100, 10'h200})
        else $error("conversion length wrong");
    power_gate_a: assert property (
        !$past(converter_power_on_o) |-> !busy_o) else $error("busy while powered down");
    busy_read_a: assert property (
        sfr_rd_i && sfr_addr_i == sarseq_pkg::OFS_CTRL_STATUS
        |=> sfr_rdata_o[0] == $past(busy_o) && !sfr_rdata_o[2]) else $error("status read bad");
    cfg_mirror_a: assert property (
        wr_cf |=> converter_power_on_o == $past(sfr_wdata_i[6])
        && autozero_ref_sel_o == $past(sfr_wdata_i[7])) else $error("config levels bad");
    ctrl_mirror_a: assert property (
        wr_cs |=> comparator_chop_off_o == $past(sfr_wdata_i[3])
        && amp_autozero_active_o == $past(sfr_wdata_i[2])) else $error("control levels bad");
    irq_cause_a: assert property (
        $rose(irq_o) |-> $fell(busy_o) || $past(sfr_wr_i) || $past(sfr_wr_i, 2)
        || $past(pwm_hw_trigger_i)) else $error("interrupt without cause");
    irq_hold_a: assert property (
        irq_o && !sfr_wr_i |=> irq_o) else $error("interrupt dropped");
    irq_clear_a: assert property (
        irq_o && wr_cs && !sfr_wdata_i[1] && !sfr_wdata_i[0] && !busy_o && !pwm_hw_trigger_i
        |=> !irq_o) else $error("done not cleared");
    start_busy_a: assert property (
        conv_start_o |-> busy_o) else $error("start while idle");

    restart_c: cover property (conv_start_o && req_r && $past(busy_o));
    irq_c: cover property ($rose(irq_o));
    finish_c: cover property ($fell(busy_o));
endmodule : sarseq_monitor

bind sarseq_top sarseq_monitor i_mon (.*);

// ### sim/sarseq_far_model.sv
`timescale 1ns/10ps
// ============================================================
// analog sources behind the multiplexer and the pwm trigger source
module sarseq_far_model (
    input  wire logic        core_clk_i,
    input  wire logic [1:0]  mux_chan_i,
    input  wire logic [1:0]  mux_sel_i,
    input  wire logic        fire_i,
    output logic      [11:0] conv_data_o,
    output logic             pwm_hw_trigger_o = 1'b0
);
    // every source carries its channel and select, so a misroute shows in the result
    assign conv_data_o = {mux_chan_i, mux_sel_i, 8'h3C};

    // one-cycle trigger pulse on the system clock
    always @(posedge core_clk_i) begin
        pwm_hw_trigger_o <= fire_i;
    end
endmodule : sarseq_far_model

// ### sim/tb.sv
`timescale 1ns/10ps
// ============================================================
// self-checking bench of the conversion sequencer
module tb;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  sfr_addr_i = 8'h00;
    logic        sfr_wr_i = 1'b0;
    logic        sfr_rd_i = 1'b0;
    logic [7:0]  sfr_wdata_i = 8'h00;
    logic        fire = 1'b0;
    logic [7:0]  sfr_rdata_o;
    logic [11:0] conv_data_i;
    logic        pwm_hw_trigger_i, converter_power_on_o, adc_clk_o, conv_start_o, busy_o;
    logic        comparator_chop_off_o, amp_autozero_active_o, autozero_ref_sel_o, irq_o;
    logic [1:0]  mux_chan_o, mux_sel_o;
    int          err_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n, g;
    logic [7:0]  o;
    logic [1:0]  s;

    sarseq_top i_dut (.*);
    sarseq_far_model i_far (.core_clk_i, .mux_chan_i(mux_chan_o), .mux_sel_i(mux_sel_o),
        .fire_i(fire), .conv_data_o(conv_data_i), .pwm_hw_trigger_o(pwm_hw_trigger_i));

    // ============================================================
    // clock and hang guard
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            stop_test();
        end
    end

    // ============================================================
    // bus and compare helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge core_clk_i);
        sfr_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge core_clk_i);
        sfr_rd_i <= 1'b0;
        #1 chk(16'(sfr_rdata_o), 16'(exp));
    endtask : rd
    // starts a sequence and logs its conversion starts
    task automatic run(input logic [7:0] ce, output int n, output int g, output logic [7:0] o,
                       output logic [1:0] s);
        int c;
        n = 0;
        c = 0;
        g = 0;
        o = 8'h00;
        wr(sarseq_pkg::OFS_CTRL_STATUS, ce);
        repeat (20000) begin
            #1;
            if (conv_start_o === 1'b1) begin
                g = c;
                o = {o[5:0], mux_chan_o};
                s = mux_sel_o;
                n++;
                c = 0;
            end
            if (busy_o !== 1'b1) break;
            c++;
            @(posedge core_clk_i);
        end
    endtask : run

    // ============================================================
    // scenarios
    task automatic t_regs();
        rd(sarseq_pkg::OFS_MUX_SELECT, sarseq_pkg::RST_MUX_SELECT);
        rd(sarseq_pkg::OFS_CONFIG_MAIN, sarseq_pkg::RST_CONFIG_MAIN);
        rd(sarseq_pkg::OFS_CTRL_STATUS, sarseq_pkg::RST_CTRL_STATUS);
        rd(8'hC0, 8'h00);
        wr(sarseq_pkg::OFS_A_RES_LOW, 8'hFF);
        rd(sarseq_pkg::OFS_A_RES_LOW, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_power();
        run(8'h8D, n, g, o, s);
        chk(16'(n), 16'h0000);
        chk(16'(adc_clk_o), 16'h0000);
        rd(sarseq_pkg::OFS_CTRL_STATUS, 8'h80);
        chk(16'(comparator_chop_off_o), 16'h0001);
        chk(16'(amp_autozero_active_o), 16'h0001);
        wr(sarseq_pkg::OFS_CONFIG_MAIN, 8'hC0);
        #1 chk(16'(autozero_ref_sel_o), 16'h0001);
        // analog bias settles for 2 us before any start
        repeat (250) @(posedge core_clk_i);
        $display("test power done");
    endtask : t_power
    task automatic t_seq();
        logic [7:0] hi[4] = '{8'hBB, 8'hBD, 8'hBF, 8'hAB};
        logic [7:0] lo[4] = '{8'hBA, 8'hBC, 8'hBE, 8'hAA};
        wr(sarseq_pkg::OFS_MUX_SELECT, 8'hE4);
        run(8'hF1, n, g, o, s);
        chk(16'(n), 16'h0004);
        chk(16'(o), 16'h001B);
        chk(16'(g), 16'h0200);
        rd(sarseq_pkg::OFS_CTRL_STATUS, 8'hF2);
        chk(16'(irq_o), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd(hi[i], 8'(3 * i + 3));
            rd(lo[i], 8'h3C);
        end
        $display("test sequence done");
    endtask : t_seq
    task automatic t_just();
        wr(sarseq_pkg::OFS_MUX_SELECT, 8'hC0);
        wr(sarseq_pkg::OFS_CONFIG_MAIN, 8'h50);
        run(8'h81, n, g, o, s);
        rd(sarseq_pkg::OFS_A_RES_HIGH, 8'h33);
        rd(sarseq_pkg::OFS_A_RES_LOW, 8'hC0);
        wr(sarseq_pkg::OFS_CONFIG_MAIN, 8'h40);
        rd(sarseq_pkg::OFS_A_RES_HIGH, 8'h03);
        rd(sarseq_pkg::OFS_A_RES_LOW, 8'h3C);
        $display("test justify done");
    endtask : t_just
    task automatic t_avg();
        wr(sarseq_pkg::OFS_MUX_SELECT, 8'hE4);
        for (int a = 0; a < 4; a++) begin
            wr(sarseq_pkg::OFS_CONFIG_MAIN, 8'h40 | 8'(a << 2));
            run(8'h51, n, g, o, s);
            chk(16'(n), 16'(2 << a));
            if (a == 0) chk(16'(o), 16'h0007);
        end
        rd(sarseq_pkg::OFS_D_RES_HIGH, 8'h0C);
        rd(sarseq_pkg::OFS_B_RES_HIGH, 8'h06);
        $display("test average done");
    endtask : t_avg
    task automatic t_div();
        // faster codes break the converter clock ceiling here; only timing and the mux select are looked at
        for (int p = 0; p < 4; p++) begin
            wr(sarseq_pkg::OFS_MUX_SELECT, 8'(p));
            wr(sarseq_pkg::OFS_CONFIG_MAIN, 8'h44 | 8'(p));
            run(8'h11, n, g, o, s);
            chk(16'(g), 16'(16 * (32 >> p)));
            chk(16'(s), 16'(p));
        end
        $display("test divider done");
    endtask : t_div
    task automatic t_abort();
        wr(sarseq_pkg::OFS_CONFIG_MAIN, 8'h60);
        wr(sarseq_pkg::OFS_CTRL_STATUS, 8'hC1);
        rd(sarseq_pkg::OFS_CTRL_STATUS, 8'hC1);
        repeat (1000) begin
            @(posedge core_clk_i);
            #1;
            if (conv_start_o === 1'b1 && mux_chan_o === 2'h1) break;
        end
        @(posedge core_clk_i);
        fire <= 1'b1;
        @(posedge core_clk_i);
        fire <= 1'b0;
        repeat (4) begin
            @(posedge core_clk_i);
            #1;
            if (conv_start_o === 1'b1) break;
        end
        chk(16'(mux_chan_o), 16'h0000);
        repeat (2000) begin
            @(posedge core_clk_i);
            #1;
            if (busy_o !== 1'b1) break;
        end
        rd(sarseq_pkg::OFS_CTRL_STATUS, 8'hCA);
        chk(16'(irq_o), 16'h0001);
        wr(sarseq_pkg::OFS_CTRL_STATUS, 8'hC0);
        rd(sarseq_pkg::OFS_CTRL_STATUS, 8'hC0);
        chk(16'(irq_o), 16'h0000);
        $display("test abort done");
    endtask : t_abort

    // ============================================================
    // verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_power();
        t_seq();
        t_just();
        t_avg();
        t_div();
        t_abort();
        stop_test();
    end
endmodule : tb
